// ==== rtl/fspc_defines.svh ====
// Constants for the flash self-programming controller: register fields,
// reset values, operation codes and timing counts.
// Assumes a 125 MHz system clock and a 24-bit program word.
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

`define FSPC_CTL_START_BIT   15
`define FSPC_CTL_PROG_EN_BIT 14
`define FSPC_CTL_ERR_BIT     13
`define FSPC_CTL_ERASE_BIT   6
`define FSPC_CTL_OP_MSB      3
`define FSPC_CTL_RESET       16'h0000
`define FSPC_KEY_RESET       16'h0000
`define FSPC_KEY_FIRST       8'h55
`define FSPC_KEY_SECOND      8'hAA
`define FSPC_CFG_SPACE_BIT   7

`define FSPC_ROW_WORDS       64
`define FSPC_ROW_BYTES       192
`define FSPC_PAGE_ROWS       8
`define FSPC_PAGE_BYTES      1536
`define FSPC_WORD_IDX_W      6
`define FSPC_PAGE_MASK       24'hFFFC00
`define FSPC_ROW_MASK        24'hFFFF80

`define FSPC_OP_BULK         4'hF
`define FSPC_OP_GEN_SEG      4'hD
`define FSPC_OP_SEC_SEG      4'hC
`define FSPC_OP_PAGE         4'h2
`define FSPC_OP_WORD         4'h3
`define FSPC_OP_ROW          4'h1
`define FSPC_OP_CFG          4'h0

`define FSPC_CLK_MHZ         125
`define FSPC_OP_TIME_US      4000
`define FSPC_OP_CYCLES       (`FSPC_OP_TIME_US * `FSPC_CLK_MHZ)
`define FSPC_TBLWT_CYCLES    2

`endif

// ==== rtl/fspc_pkg.sv ====
// Types shared by the flash self-programming controller files.
// Assumes fspc_defines.svh for the numeric constants.
package fspc_pkg;

	typedef enum logic [3:0] {
		FSPC_NONE     = 4'h0,
		FSPC_ERASE    = 4'h1,
		FSPC_PROG_ROW = 4'h2,
		FSPC_PROG_ONE = 4'h4
	} fspc_kind_t;

	typedef enum logic [3:0] {
		FSPC_IDLE  = 4'h1,
		FSPC_BUSY  = 4'h2,
		FSPC_WRITE = 4'h4,
		FSPC_DONE  = 4'h8
	} fspc_state_t;

endpackage : fspc_pkg

// ==== rtl/fspc_row_buffer.sv ====
// Holding buffer of one row of program words for the self-programmer.
// Assumes writes come from table writes on the same clock.
`timescale 1ns/100ps
`include "fspc_defines.svh"

module fspc_row_buffer (
	input  wire logic        clk,
	input  wire logic        wr_lo,
	input  wire logic        wr_hi,
	input  wire logic [1:0]  byte_en,
	input  wire logic [5:0]  wr_idx,
	input  wire logic [15:0] wr_data,
	input  wire logic [5:0]  rd_idx,
	output logic      [23:0] rd_word
);

	// Buffer words only; no flash cell changes here
	logic [23:0] mem [0:`FSPC_ROW_WORDS-1];

	always_ff @(posedge clk)
	begin
		if (wr_lo && byte_en[0])
			mem[wr_idx][7:0] <= wr_data[7:0];
		if (wr_lo && byte_en[1])
			mem[wr_idx][15:8] <= wr_data[15:8];
		if (wr_hi && byte_en[0])
			mem[wr_idx][23:16] <= wr_data[7:0];
	end

	assign rd_word = mem[rd_idx];

endmodule : fspc_row_buffer

// ==== rtl/fspc_key_guard.sv ====
// Unlock key tracker: arms after 0x55 then 0xAA on consecutive
// register writes. Any other register write disarms it.
`timescale 1ns/100ps
`include "fspc_defines.svh"

module fspc_key_guard (
	input  wire logic       clk,
	input  wire logic       por,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	input  wire logic       other_wr,
	output logic            armed
);

	typedef struct packed {
		logic got_first;
		logic armed;
	} fspc_key_st_t;

	fspc_key_st_t s_r;
	fspc_key_st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (key_wr)
		begin
			// Back-to-back pair only
			s_nxt.armed     = s_r.got_first &&
				(key_data == `FSPC_KEY_SECOND);
			s_nxt.got_first = (key_data == `FSPC_KEY_FIRST);
		end
		else if (other_wr)
		begin
			// Any control write consumes the key
			s_nxt.got_first = 1'b0;
			s_nxt.armed     = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (por)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign armed = s_r.armed;

endmodule : fspc_key_guard

// ==== rtl/fspc_ctrl.sv ====
// Top of the flash self-programming controller: table access, control
// and key registers, operation sequencer and processor stall.
// Assumes the core issues one table or register access per cycle and
// that srst is the power-on reset; other resets never reach here.
`timescale 1ns/100ps
`include "fspc_defines.svh"

module fspc_ctrl #(
	parameter int unsigned OP_CYCLES = `FSPC_OP_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  table_page_reg,
	input  wire logic [15:0] effective_address,
	input  wire logic        table_read_low,
	input  wire logic        table_read_high,
	input  wire logic        table_write_low,
	input  wire logic        table_write_high,
	input  wire logic        tbl_byte_mode,
	input  wire logic [15:0] tbl_wdata,
	input  wire logic        ctl_wr,
	input  wire logic        ctl_rd,
	input  wire logic        key_wr,
	input  wire logic        key_rd,
	input  wire logic [15:0] reg_wdata,
	input  wire logic [23:0] flash_rdata,
	input  wire logic        flash_ready,
	output logic      [15:0] rdata,
	output logic             rdata_valid,
	output logic      [23:0] flash_addr,
	output logic             flash_cfg_space,
	output logic             flash_rd,
	output logic      [3:0]  flash_cmd,
	output logic             flash_cmd_valid,
	output logic      [23:0] flash_wdata,
	output logic             flash_wdata_valid,
	output logic             cpu_stall
);

	typedef struct packed {
		logic                       start;
		logic                       prog_en;
		logic                       err;
		logic                       erase_sel;
		logic [3:0]                 opcode;
		fspc_pkg::fspc_state_t      state;
		fspc_pkg::fspc_kind_t       kind;
		logic [31:0]                timer;
		logic [5:0]                 wr_idx;
		logic [23:0]                op_addr;
		logic                       tw_busy;
		logic                       rd_pend;
		logic                       rd_high;
		logic                       rd_bsel;
		logic                       rd_byte;
		logic [15:0]                rdata;
		logic                       rdata_valid;
		logic [23:0]                flash_addr;
		logic                       flash_cfg;
		logic                       flash_rd;
		logic [3:0]                 flash_cmd;
		logic                       flash_cmd_valid;
		logic [23:0]                flash_wdata;
		logic                       flash_wdata_valid;
		logic                       stall;
		logic                       stall_out;
	} fspc_st_t;

	fspc_st_t s_r;
	fspc_st_t s_nxt;

	logic        key_armed;
	logic [5:0]  buf_idx;
	logic [23:0] buf_word;
	logic [1:0]  buf_be;
	logic [23:0] tbl_addr;
	logic        tbl_wr;

	// Decode of start request into an operation kind
	function automatic fspc_pkg::fspc_kind_t op_kind(
		input logic       erase,
		input logic [3:0] op
	);
		fspc_pkg::fspc_kind_t k;
		k = fspc_pkg::FSPC_NONE;
		if (erase)
		begin
			case (op)
				`FSPC_OP_BULK,
				`FSPC_OP_GEN_SEG,
				`FSPC_OP_SEC_SEG,
				`FSPC_OP_PAGE,
				`FSPC_OP_CFG:   k = fspc_pkg::FSPC_ERASE;
				default:        k = fspc_pkg::FSPC_NONE;
			endcase
		end
		else
		begin
			case (op)
				`FSPC_OP_ROW:   k = fspc_pkg::FSPC_PROG_ROW;
				`FSPC_OP_WORD,
				`FSPC_OP_CFG:   k = fspc_pkg::FSPC_PROG_ONE;
				default:        k = fspc_pkg::FSPC_NONE;
			endcase
		end
		return k;
	endfunction : op_kind

	// Word index inside a row; rows begin at row multiples
	function automatic logic [5:0] row_index(input logic [23:0] a);
		return a[6:1];
	endfunction : row_index

	// Array address of an operation. Erase pages and program rows are
	// aligned down, so a pointer left mid-row still hits its own row
	function automatic logic [23:0] op_target(
		input logic        erase,
		input logic [3:0]  op,
		input logic [23:0] a
	);
		logic [23:0] t;
		t = a;
		if (erase)
		begin
			if (op == `FSPC_OP_PAGE)
				t = a & `FSPC_PAGE_MASK;
		end
		else
		begin
			if (op == `FSPC_OP_ROW)
				t = a & `FSPC_ROW_MASK;
			else
				t = {a[23:1], 1'b0};
		end
		return t;
	endfunction : op_target

	// Page byte on top, effective address below; LSb passes through unchanged
	assign tbl_addr = {table_page_reg, effective_address};
	assign tbl_wr   = table_write_low | table_write_high;
	assign buf_idx  = row_index(tbl_addr);
	assign buf_be   = tbl_byte_mode ?
		(effective_address[0] ? 2'b10 : 2'b01) : 2'b11;

	fspc_row_buffer u_buf (
		.clk     (clk),
		.wr_lo   (table_write_low),
		.wr_hi   (table_write_high),
		.byte_en (table_write_high ? 2'b01 : buf_be),
		.wr_idx  (buf_idx),
		.wr_data (tbl_byte_mode && effective_address[0] &&
			!table_write_high ? {tbl_wdata[7:0], 8'h00} : tbl_wdata),
		.rd_idx  (s_r.wr_idx),
		.rd_word (buf_word)
	);

	fspc_key_guard u_key (
		.clk      (clk),
		.por      (srst),
		.key_wr   (key_wr),
		.key_data (reg_wdata[7:0]),
		.other_wr (ctl_wr),
		.armed    (key_armed)
	);

	always_comb
	begin
		s_nxt                   = s_r;
		s_nxt.rdata_valid       = 1'b0;
		s_nxt.flash_rd          = 1'b0;
		s_nxt.flash_cmd_valid   = 1'b0;
		s_nxt.flash_wdata_valid = 1'b0;
		s_nxt.tw_busy           = 1'b0;

		// Buffer write holds the core one extra cycle
		if (tbl_wr && !s_r.tw_busy)
			s_nxt.tw_busy = 1'b1;
		if (tbl_wr)
			s_nxt.op_addr = tbl_addr;

		if (table_read_low || table_read_high)
		begin
			s_nxt.flash_addr = tbl_addr;
			s_nxt.flash_cfg  = table_page_reg[`FSPC_CFG_SPACE_BIT];
			s_nxt.flash_rd   = 1'b1;
			s_nxt.rd_pend    = 1'b1;
			s_nxt.rd_high    = table_read_high;
			s_nxt.rd_bsel    = effective_address[0];
			s_nxt.rd_byte    = tbl_byte_mode;
		end
		else if (s_r.rd_pend && flash_ready)
		begin
			s_nxt.rd_pend     = 1'b0;
			s_nxt.rdata_valid = 1'b1;
			if (s_r.rd_high)  // Phantom byte reads zero
				s_nxt.rdata = (s_r.rd_byte && s_r.rd_bsel) ? 16'h0000 :
					{8'h00, flash_rdata[23:16]};
			else if (s_r.rd_byte)
				s_nxt.rdata = {8'h00, s_r.rd_bsel ? flash_rdata[15:8] :
					flash_rdata[7:0]};
			else
				s_nxt.rdata = flash_rdata[15:0];
		end
		else if (ctl_rd)
		begin
			s_nxt.rdata_valid = 1'b1;
			s_nxt.rdata = {s_r.start, s_r.prog_en, s_r.err, 6'h00,
				s_r.erase_sel, 2'h0, s_r.opcode};
		end
		else if (key_rd)
		begin
			// Key is write-only; the whole word reads zero
			s_nxt.rdata_valid = 1'b1;
			s_nxt.rdata       = 16'h0000;
		end

		if (ctl_wr && s_r.state == fspc_pkg::FSPC_IDLE)
		begin
			s_nxt.prog_en   = reg_wdata[`FSPC_CTL_PROG_EN_BIT];
			s_nxt.erase_sel = reg_wdata[`FSPC_CTL_ERASE_BIT];
			s_nxt.opcode    = reg_wdata[`FSPC_CTL_OP_MSB:0];
			if (!reg_wdata[`FSPC_CTL_ERR_BIT])
				s_nxt.err = 1'b0;
			if (reg_wdata[`FSPC_CTL_START_BIT])  // Set-only bit
			begin
				s_nxt.kind = op_kind(reg_wdata[`FSPC_CTL_ERASE_BIT],
					reg_wdata[`FSPC_CTL_OP_MSB:0]);
				if (!key_armed || !reg_wdata[`FSPC_CTL_PROG_EN_BIT])
					s_nxt.err = 1'b1;
				else if (s_nxt.kind != fspc_pkg::FSPC_NONE)
				begin
					// One start per row or word
					s_nxt.start      = 1'b1;
					s_nxt.err        = 1'b0;
					s_nxt.stall      = 1'b1;
					s_nxt.timer      = 32'(OP_CYCLES);
					// A single word streams from its own buffer slot
					if (s_nxt.kind == fspc_pkg::FSPC_PROG_ONE)
					begin
						s_nxt.wr_idx = row_index(s_r.op_addr);
					end
					else
					begin
						s_nxt.wr_idx = 6'h00;
					end
					s_nxt.state      = fspc_pkg::FSPC_BUSY;
					s_nxt.flash_addr = op_target(
						reg_wdata[`FSPC_CTL_ERASE_BIT],
						reg_wdata[`FSPC_CTL_OP_MSB:0], s_r.op_addr);
					s_nxt.flash_cfg  =
						s_r.op_addr[16 + `FSPC_CFG_SPACE_BIT];
					s_nxt.flash_cmd  = reg_wdata[`FSPC_CTL_OP_MSB:0];
					s_nxt.flash_cmd_valid = 1'b1;
				end
			end
		end

		case (s_r.state)
			fspc_pkg::FSPC_IDLE:
				;
			fspc_pkg::FSPC_BUSY:
			begin
				if (s_r.kind != fspc_pkg::FSPC_ERASE)
					s_nxt.state = fspc_pkg::FSPC_WRITE;
				else if (s_r.timer <= 32'd1)
					s_nxt.state = fspc_pkg::FSPC_DONE;
				s_nxt.timer = s_r.timer - 32'd1;
			end
			fspc_pkg::FSPC_WRITE:
			begin
				// Stream the buffer to the array in order
				s_nxt.flash_wdata       = buf_word;
				s_nxt.flash_wdata_valid = 1'b1;
				s_nxt.timer             = s_r.timer - 32'd1;
				if (s_r.kind == fspc_pkg::FSPC_PROG_ONE ||
					s_r.wr_idx == 6'(`FSPC_ROW_WORDS - 1))
					s_nxt.state = fspc_pkg::FSPC_BUSY;
				else
					s_nxt.wr_idx = s_r.wr_idx + 6'h01;
				if (s_nxt.state == fspc_pkg::FSPC_BUSY)
					s_nxt.kind = fspc_pkg::FSPC_ERASE;
			end
			fspc_pkg::FSPC_DONE:
			begin
				s_nxt.start = 1'b0;  // Hardware clears
				s_nxt.stall = 1'b0;
				s_nxt.state = fspc_pkg::FSPC_IDLE;
			end
			default:
				s_nxt.state = fspc_pkg::FSPC_IDLE;
		endcase

		// Stall leaves a flop of its own; the extra table-write cycle
		// and the operation stall both hold the core
		s_nxt.stall_out = s_nxt.stall | s_nxt.tw_busy;
	end

	// Only power-on reset reaches these bits
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_r       <= '0;
			s_r.state <= fspc_pkg::FSPC_IDLE;
			s_r.kind  <= fspc_pkg::FSPC_NONE;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata             = s_r.rdata;
	assign rdata_valid       = s_r.rdata_valid;
	assign flash_addr        = s_r.flash_addr;
	assign flash_cfg_space   = s_r.flash_cfg;
	assign flash_rd          = s_r.flash_rd;
	assign flash_cmd         = s_r.flash_cmd;
	assign flash_cmd_valid   = s_r.flash_cmd_valid;
	assign flash_wdata       = s_r.flash_wdata;
	assign flash_wdata_valid = s_r.flash_wdata_valid;
	// Table write adds one cycle; operation holds the core throughout
	assign cpu_stall         = s_r.stall_out;

endmodule : fspc_ctrl

// ==== verification/fspc_ctrl_checker.sv ====
// Assertion checker for the flash self-programming controller.
// Bound into fspc_ctrl and sees only a subset of its ports.
`timescale 1ns/100ps
module fspc_ctrl_checker #(
	parameter int unsigned OP_CYCLES = 100
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        table_read_low,
	input  wire logic        table_read_high,
	input  wire logic        table_write_low,
	input  wire logic        ctl_wr,
	input  wire logic        key_rd,
	input  wire logic [15:0] reg_wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        rdata_valid,
	input  wire logic        flash_rd,
	input  wire logic [3:0]  flash_cmd,
	input  wire logic        flash_cmd_valid,
	input  wire logic        flash_wdata_valid,
	input  wire logic        cpu_stall
);
	// Stall drops one cycle after the timer ends; three cycles of slack on top
	localparam int OP_MAX = OP_CYCLES + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_cmd_from_start: assert property (
		flash_cmd_valid |-> $past(ctl_wr) && $past(reg_wdata[15]))
		else $error("command launched without a start write");
	a_cmd_needs_program_enable_bit: assert property (
		flash_cmd_valid |-> $past(reg_wdata[14]))
		else $error("command launched with program enable clear");
	a_cmd_code_legal: assert property (
		flash_cmd_valid |-> flash_cmd inside
		{4'hF, 4'hD, 4'hC, 4'h3, 4'h2, 4'h1, 4'h0})
		else $error("unimplemented operation code launched");
	a_op_stalls: assert property (
		flash_cmd_valid |-> cpu_stall [*8])
		else $error("stall missing during operation");
	a_op_ends: assert property (
		flash_cmd_valid |-> ##[1:OP_MAX] !cpu_stall)
		else $error("operation stall too long");
	a_key_reads_zero: assert property (
		key_rd |=> rdata_valid && rdata == 16'h0000)
		else $error("key register read not zero");
	a_tblwt_two_cyc: assert property (
		table_write_low && !cpu_stall |=> cpu_stall ##1 !cpu_stall)
		else $error("table write not two cycles");
	a_tblrd_fetch: assert property (
		(table_read_low || table_read_high) |=> flash_rd)
		else $error("table read without array read");
	a_tblrd_answer: assert property (
		flash_rd |-> ##[1:12] rdata_valid)
		else $error("table read not answered");
	a_wdata_in_op: assert property (
		flash_wdata_valid |-> cpu_stall)
		else $error("buffer word streamed outside operation");
	c_row_prog: cover property (flash_cmd_valid && flash_cmd == 4'h1);
	c_read_done: cover property (rdata_valid);
	c_tbl_write: cover property (table_write_low);
endmodule : fspc_ctrl_checker

bind fspc_ctrl fspc_ctrl_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (.*);

// ==== verification/fspc_flash_model.sv ====
// Behavioural program flash array that answers the controller's reads.
// Ready returns after a latency the bench picks for each read.
`timescale 1ns/100ps
module fspc_flash_model (
	input  wire logic        clk,
	input  wire logic        flash_rd,
	input  wire logic [23:0] flash_addr,
	input  wire logic        flash_cfg_space,
	input  wire logic [3:0]  lat,
	output logic      [23:0] flash_rdata,
	output logic             flash_ready
);
	int          cnt = -1;
	logic [23:0] word;
	initial
	begin
		flash_rdata = 24'h000000;
		flash_ready = 1'b0;
	end
	always @(posedge clk)
	begin
		flash_ready <= 1'b0;
		// Data toggles between answers so stale data never matches
		flash_rdata <= ~flash_rdata;
		if (flash_rd)
		begin
			// Content differs between user and configuration space
			word = {flash_addr[23:1], 1'b0} ^ {flash_cfg_space, 23'h35A5C3};
			cnt = lat;
		end
		else if (cnt > 0)
			cnt = cnt - 1;
		if (cnt == 0)
		begin
			flash_ready <= 1'b1;
			flash_rdata <= word;
			cnt = -1;
		end
	end
endmodule : fspc_flash_model

// ==== verification/flash_self_program_ctrl_tb_top.sv ====
// Self-checking bench for the flash self-programming controller.
// Core side driven 1 ns after each rising edge; flash model answers.
`timescale 1ns/100ps
module flash_self_program_ctrl_tb_top;
	localparam int unsigned OPC = 100;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  page = 8'h00;
	logic [15:0] eff_addr = 16'h0000;
	logic        rd_lo = 0, rd_hi = 0, wr_lo = 0, wr_hi = 0, bmode = 0;
	logic        ctl_wr = 0, ctl_rd = 0, key_wr = 0, key_rd = 0;
	logic [15:0] twdata = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [3:0]  lat = 4'h0;
	logic [23:0] frdata, faddr, fwdata;
	logic        fready, rvalid, fcfg, frd, fcmdv, fwdv, stall;
	logic [15:0] rdata;
	logic [3:0]  fcmd;
	logic [23:0] exp_q[$];
	int          fail_count = 0;
	int          n_tests = 0;
	int          cyc = 0;

	fspc_ctrl #(.OP_CYCLES(OPC)) dut (.clk(clk), .srst(srst),
		.table_page_reg(page), .effective_address(eff_addr),
		.table_read_low(rd_lo), .table_read_high(rd_hi),
		.table_write_low(wr_lo), .table_write_high(wr_hi),
		.tbl_byte_mode(bmode), .tbl_wdata(twdata), .ctl_wr(ctl_wr),
		.ctl_rd(ctl_rd), .key_wr(key_wr), .key_rd(key_rd),
		.reg_wdata(wdata), .flash_rdata(frdata), .flash_ready(fready),
		.rdata(rdata), .rdata_valid(rvalid), .flash_addr(faddr),
		.flash_cfg_space(fcfg), .flash_rd(frd), .flash_cmd(fcmd),
		.flash_cmd_valid(fcmdv), .flash_wdata(fwdata),
		.flash_wdata_valid(fwdv), .cpu_stall(stall));
	fspc_flash_model u_flash (.clk(clk), .flash_rd(frd),
		.flash_addr(faddr), .flash_cfg_space(fcfg), .lat(lat),
		.flash_rdata(frdata), .flash_ready(fready));

	initial
	begin
		forever #4 clk = ~clk;
	end
	// Whole run takes under two thousand cycles; this only cuts a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic reg_wr(input bit key, input logic [15:0] d);
		// Idle edge first, so no strobe is set where it was just cleared
		step();
		wdata = d;
		key_wr = key;
		ctl_wr = !key;
		step();
		key_wr = 0;
		ctl_wr = 0;
	endtask : reg_wr
	task automatic reg_rd(input bit key, output logic [15:0] d);
		step();
		key_rd = key;
		ctl_rd = !key;
		step();
		key_rd = 0;
		ctl_rd = 0;
		chk("read valid", rvalid, 1);
		d = rdata;
	endtask : reg_rd
	task automatic tbl_rd(input bit hi, output logic [15:0] d);
		int n;
		rd_hi = hi;
		rd_lo = !hi;
		step();
		rd_hi = 0;
		rd_lo = 0;
		for (n = 0; n < 20 && rvalid !== 1'b1; n++)
			step();
		d = rdata;
	endtask : tbl_rd
	task automatic tbl_wr(input bit hi, input logic [15:0] d);
		wr_hi = hi;
		wr_lo = !hi;
		twdata = d;
		step();
		wr_hi = 0;
		wr_lo = 0;
		chk("write stall", stall, 1);
		step();
	endtask : tbl_wr
	task automatic run_op(input logic [15:0] ctl, input bit key);
		int n, words, nw;
		bit ran, go, err;
		logic [15:0] d;
		err = !(key && ctl[14]);
		go = !err && (ctl[6] ? ctl[3:0] inside {4'hF, 4'hD, 4'hC, 4'h2,
			4'h0} : ctl[3:0] inside {4'h3, 4'h1, 4'h0});
		nw = (!go || ctl[6]) ? 0 : (ctl[3:0] == 4'h1) ? 64 : 1;
		// Fields set and error flag cleared before the key
		reg_wr(0, ctl & 16'h5FFF);
		if (key)
		begin
			reg_wr(1, 16'h0055);
			reg_wr(1, 16'h00AA);
		end
		reg_wr(0, ctl);
		ran = 0;
		words = 0;
		for (n = 0; n < OPC + 80; n++)
		begin
			if (fcmdv === 1'b1)
				ran = 1;
			if (fcmdv === 1'b1)
				chk("op code", fcmd, ctl[3:0]);
			if (fwdv === 1'b1)
				words++;
			if (fwdv === 1'b1 && exp_q.size() > 0)
				chk("row word", fwdata, exp_q.pop_front());
			if (n > 2 && stall !== 1'b1)
				break;
			step();
		end
		chk("op ran", ran, go);
		chk("words streamed", words, nw);
		if (go)
			chk("op length ok", n >= OPC && n <= OPC + 3, 1);
		step();
		step();
		reg_rd(0, d);
		chk("control", d, {1'b0, ctl[14], err, 6'h00, ctl[6], 2'h0,
			ctl[3:0]});
	endtask : run_op
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	initial
	begin : main
		logic [15:0] d, lo;
		logic [7:0]  hi;
		logic [23:0] w;
		logic [3:0]  ops[8] = '{4'hF, 4'hD, 4'hC, 4'h3, 4'h2, 4'h1,
			4'h0, 4'h7};
		void'($urandom(61305));
		repeat (16) step();
		srst = 0;
		reg_rd(1, d);
		chk("key read", d, 16'h0000);
		reg_rd(0, d);
		chk("control reset", d, 16'h0000);
		for (int i = 0; i < 6; i++)
		begin
			page = $urandom;
			eff_addr = $urandom & 16'hFFFE;
			bmode = 0;
			lat = $urandom % 4;
			w = {page, eff_addr} ^ {page[7], 23'h35A5C3};
			tbl_rd(0, d);
			chk("low word", d, w[15:0]);
			chk("flash address", faddr, {page, eff_addr});
			chk("space select", fcfg, page[7]);
			tbl_rd(1, d);
			chk("high byte", d, {8'h00, w[23:16]});
			bmode = 1;
			eff_addr[0] = 1;
			tbl_rd(0, d);
			chk("low upper byte", d[7:0], w[15:8]);
		end
		run_op(16'hC042, 0);
		run_op(16'h8042, 1);
		foreach (ops[k])
		begin
			run_op(16'hC040 | ops[k], 1);
			run_op(16'hC000 | ops[k], 1);
		end
		page = 8'h00;
		bmode = 0;
		// One aligned 64-word group, low then high per word
		for (int i = 0; i < 64; i++)
		begin
			eff_addr = 16'h0180 + 16'(2 * i);
			lo = $urandom;
			hi = $urandom;
			tbl_wr(0, lo);
			tbl_wr(1, {8'h00, hi});
			exp_q.push_back({hi, lo});
		end
		run_op(16'hC001, 1);
		chk("row fully streamed", exp_q.size(), 0);
		chk("row address", faddr, 24'h000180);
		report_and_stop();
	end : main
endmodule : flash_self_program_ctrl_tb_top
